// [dv/hall_motor_model.sv]
// Hall sensor model of the motor at the far side of the block
`timescale 1ns/1ps
module hall_motor_model (
  input wire logic clk_sys,
  input wire logic load,
  input wire logic [2:0] load_code,
  input wire logic advance,
  output logic [2:0] hall_pins
);
  logic [2:0] code_reg = 3'h5;
  // Forward rotation; each step crosses one 60 degree sector
  function automatic logic [2:0] next_code(input logic [2:0] c);
    case (c)
      3'h5: next_code = 3'h4;
      3'h4: next_code = 3'h6;
      3'h6: next_code = 3'h2;
      3'h2: next_code = 3'h3;
      3'h3: next_code = 3'h1;
      3'h1: next_code = 3'h5;
      default: next_code = c;
    endcase
  endfunction
  // Broken wiring is modelled by loading codes 0 or 7 directly
  always @(posedge clk_sys) begin
    if (load) begin
      code_reg <= load_code;
    end else if (advance) begin
      code_reg <= next_code(code_reg);
    end
  end
  assign hall_pins = code_reg;
endmodule

// [dv/testbench.sv]
// Self-checking bench for the Hall sine commutation init block
`timescale 1ns/1ps
module testbench;
  localparam int angle_full = 32'(sine_commut_pkg::ANGLE_FULL);
  localparam int sector = 32'(sine_commut_pkg::SECTOR_STEP);
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic [2:0] hall_pins;
  logic [13:0] motion_angle_delta = 14'h0000;
  logic motion_step = 1'b0;
  logic phase_found = 1'b0;
  logic [13:0] commutation_angle;
  logic sine_drive_en;
  logic forced_phase_run;
  logic min_motion_run;
  logic hm_load = 1'b0;
  logic hm_adv = 1'b0;
  logic [2:0] hm_code = 3'h5;
  logic rd_phase = 1'b0;
  logic [31:0] rng = 32'h95fe_2117;
  logic [2:0] rot [6] = '{3'h5, 3'h4, 3'h6, 3'h2, 3'h3, 3'h1};
  logic [2:0] mt_bad [3] = '{3'h1, 3'h2, 3'h0};
  logic [63:0] exp_q [$];
  int err_total = 0;
  int checks_done = 0;

  hall_sine_commutation_init dut (.clk_sys(clk_sys), .reset(reset), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .hall_pins(hall_pins), .motion_angle_delta(motion_angle_delta),
    .motion_step(motion_step), .phase_found(phase_found),
    .commutation_angle(commutation_angle), .sine_drive_en(sine_drive_en),
    .forced_phase_run(forced_phase_run), .min_motion_run(min_motion_run));
  hall_motor_model hall_model (.clk_sys(clk_sys), .load(hm_load), .load_code(hm_code),
    .advance(hm_adv), .hall_pins(hall_pins));

  always #50 clk_sys = ~clk_sys;

  task automatic chk(input logic [31:0] seen, input logic [31:0] expv);
    checks_done++;
    if (seen !== expv) begin
      err_total++;
      $display("[ERR] %0t ns: seen %h expected %h", $time, seen, expv);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    xs = t ^ (t << 5);
  endfunction

  function automatic logic [31:0] wrapa(input int v);
    wrapa = 32'((v + 2 * angle_full) % angle_full);
  endfunction

  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (hreadyout !== 1'b1 && n < 64);
    if (hreadyout !== 1'b1) begin
      err_total++;
      $display("[ERR] %0t ns: bus wait timed out", $time);
      test_done();
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk_sys);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h00_0000, a};
    hwrite <= w;
    wait_ready();
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    rd_phase <= ~w;
    wait_ready();
    rd_phase <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    exp_q.push_back({m, e & m});
    bus(1'b0, a, 32'h0000_0000);
  endtask

  // Read data is taken at the edge that ends the data phase
  always @(posedge clk_sys) begin
    logic [63:0] e;
    if (rd_phase && hreadyout && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      chk(hrdata & e[63:32], e[31:0]);
      chk(32'(hresp), 32'h0000_0000);
    end
  end

  task automatic do_reset();
    @(posedge clk_sys);
    reset <= 1'b1;
    repeat (3) @(posedge clk_sys);
    reset <= 1'b0;
  endtask

  task automatic pulse(input int which, input int d);
    @(posedge clk_sys);
    motion_angle_delta <= 14'(d);
    motion_step <= (which == 0);
    phase_found <= (which == 1);
    @(posedge clk_sys);
    motion_step <= 1'b0;
    phase_found <= 1'b0;
    repeat (3) @(posedge clk_sys);
  endtask

  task automatic hall_set(input logic [2:0] c);
    @(posedge clk_sys);
    hm_load <= 1'b1;
    hm_code <= c;
    @(posedge clk_sys);
    hm_load <= 1'b0;
    repeat (4) @(posedge clk_sys);
  endtask

  task automatic hall_adv();
    @(posedge clk_sys);
    hm_adv <= 1'b1;
    @(posedge clk_sys);
    hm_adv <= 1'b0;
    repeat (4) @(posedge clk_sys);
  endtask

  task automatic setup(input logic [2:0] mt, input logic twoph);
    wr(sine_commut_pkg::OFF_CTRL, {20'h0_0000, 4'h1, 2'h0, twoph, 1'b1, 1'b0, mt});
    wr(sine_commut_pkg::OFF_CMD, {29'h0000_0000, sine_commut_pkg::CMD_SINE_AXIS});
  endtask

  initial begin
    int off;
    int a0;
    int d;
    repeat (3) @(posedge clk_sys);
    reset <= 1'b0;
    rd(sine_commut_pkg::OFF_CTRL, 32'h0000_0F37, 32'h0000_0101);
    rd(sine_commut_pkg::OFF_OFFSET, 32'h0000_FFFF, 32'h0000_0000);
    rd(sine_commut_pkg::OFF_STATUS, 32'hF000_07F0, 32'h0000_0040);
    rd(8'h3C, 32'hFFFF_FFFF, 32'h0000_0000);
    wr(sine_commut_pkg::OFF_OFFSET, 32'h0000_3000);
    rd(sine_commut_pkg::OFF_OFFSET, 32'h0000_FFFF, 32'h0000_2CFF);
    wr(sine_commut_pkg::OFF_OFFSET, 32'h0000_8000);
    rd(sine_commut_pkg::OFF_OFFSET, 32'h0000_FFFF, 32'h0000_9301);
    rd(sine_commut_pkg::OFF_MCYCLE, 32'hFFFF_FFFF, 32'h0000_0000);
    setup(sine_commut_pkg::MT_SERVO_POS, 1'b0);
    rd(sine_commut_pkg::OFF_STATUS, 32'hF000_0010, 32'h1000_0010);
    for (int c = 0; c < 8; c++) begin
      hall_set(3'(c));
      rd(sine_commut_pkg::OFF_STATUS, 32'h0000_0007, 32'(c));
    end
    wr(sine_commut_pkg::OFF_CMD, {29'h0000_0000, sine_commut_pkg::CMD_SINE_OFF});
    rd(sine_commut_pkg::OFF_STATUS, 32'hF000_0010, 32'h0000_0000);
    $display("setup and readback done");
    for (int k = 0; k < 4; k++) begin
      do_reset();
      if (k < 3) setup(mt_bad[k], k == 0);
      wr(sine_commut_pkg::OFF_CMD, {29'h0000_0000, sine_commut_pkg::CMD_HALL_CAL});
      rd(sine_commut_pkg::OFF_STATUS, 32'h0000_00A0, 32'h0000_0020);
    end
    $display("refusals done");
    for (int i = 0; i < 6; i++) begin
      do_reset();
      hall_set(rot[i]);
      rng = xs(rng);
      off = int'(rng % 32'h0000_2CFF);
      if (rng[31]) off = -off;
      setup(i[0] ? sine_commut_pkg::MT_SERVO_NEG : sine_commut_pkg::MT_SERVO_POS, 1'b0);
      wr(sine_commut_pkg::OFF_MCYCLE, {16'h0000, rng[15:0]});
      rd(sine_commut_pkg::OFF_MCYCLE, 32'h0000_FFFF, {16'h0000, rng[15:0]});
      // Offset is lost at reset, so software writes it again every time
      wr(sine_commut_pkg::OFF_OFFSET, {16'h0000, off < 0, 1'b0, 14'(off)});
      wr(sine_commut_pkg::OFF_CMD, {29'h0000_0000, sine_commut_pkg::CMD_HALL_CAL});
      rd(sine_commut_pkg::OFF_STATUS, 32'h0000_07E0, 32'h0000_0080);
      chk(32'(commutation_angle), wrapa(i * sector + off));
      hall_set(i[0] ? 3'h7 : 3'h0);
      chk(32'(commutation_angle), wrapa(i * sector + off));
      chk(32'(sine_drive_en), 32'h0000_0000);
      hall_set(rot[(i + 1) % 6]);
      chk(32'(commutation_angle), wrapa(((i + 1) % 6) * sector + off));
      chk(32'(sine_drive_en), 32'h0000_0001);
      rd(sine_commut_pkg::OFF_STATUS, 32'h0000_07C0, 32'h0000_0400);
      // Hall edges after the first no longer steer the angle
      hall_adv();
      chk(32'(commutation_angle), wrapa(((i + 1) % 6) * sector + off));
      a0 = angle_full - 1 - i * 7;
      wr(sine_commut_pkg::OFF_ANGLE, 32'(a0));
      wr(sine_commut_pkg::OFF_ANGLE, 32'h0000_2D00);
      rd(sine_commut_pkg::OFF_ANGLE, 32'h0000_3FFF, 32'(a0));
      rng = xs(rng);
      d = int'(rng % 32'h0000_2D00);
      pulse(0, d);
      chk(32'(commutation_angle), wrapa(a0 + d));
    end
    $display("hall calibration done");
    for (int j = 0; j < 2; j++) begin
      do_reset();
      setup(sine_commut_pkg::MT_SERVO_POS, 1'b0);
      wr(sine_commut_pkg::OFF_CMD, {29'h0000_0000, j == 0 ? sine_commut_pkg::CMD_FORCED :
        sine_commut_pkg::CMD_MINFIND});
      rd(sine_commut_pkg::OFF_STATUS, 32'h0000_07C0, j == 0 ? 32'h0000_0100 :
        32'h0000_0200);
      chk(32'({forced_phase_run, min_motion_run}), j == 0 ? 32'h0000_0002 :
        32'h0000_0001);
      pulse(1, 0);
      chk(32'({sine_drive_en, forced_phase_run, min_motion_run}), 32'h0000_0004);
    end
    $display("alternative init done");
    test_done();
  end
endmodule

// [rtl/hall_sector_decode.sv]
// Hall state register and sector decoder with invalid-code hold
`timescale 1ns/1ps
module hall_sector_decode (
  input wire logic clk_sys,
  input wire logic reset,
  hall_sector_if.decoder hs
);
  logic [2:0] state_reg;
  logic [2:0] state_next;
  logic [13:0] sect_reg;
  logic [13:0] sect_next;
  logic seen_reg;
  logic seen_next;
  logic trans_reg;
  logic trans_next;
  logic valid_code;

  assign valid_code = (hs.hall_raw != 3'h0) && (hs.hall_raw != 3'h7);

  always_comb begin
    state_next = hs.hall_raw;
    sect_next = sect_reg;
    seen_next = seen_reg;
    trans_next = 1'b0;
    if (valid_code) begin
      seen_next = 1'b1;
      case (hs.hall_raw)
        3'h5: sect_next = 14'(sine_commut_pkg::SECTOR_STEP * 0);
        3'h4: sect_next = 14'(sine_commut_pkg::SECTOR_STEP * 1);
        3'h6: sect_next = 14'(sine_commut_pkg::SECTOR_STEP * 2);
        3'h2: sect_next = 14'(sine_commut_pkg::SECTOR_STEP * 3);
        3'h3: sect_next = 14'(sine_commut_pkg::SECTOR_STEP * 4);
        default: sect_next = 14'(sine_commut_pkg::SECTOR_STEP * 5);
      endcase
      // Compare sectors, not raw codes, so a glitch through 0 or 7 back to the same code does not count
      trans_next = seen_reg && (sect_next != sect_reg);
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state_reg <= 3'h0;
      sect_reg <= 14'h0000;
      seen_reg <= 1'b0;
      trans_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      sect_reg <= sect_next;
      seen_reg <= seen_next;
      trans_reg <= trans_next;
    end
  end

  assign hs.hall_state = state_reg;
  assign hs.sector_angle = sect_reg;
  assign hs.sector_valid = seen_reg;
  assign hs.transition = trans_reg;

  hold_invalid_a: assert property (@(posedge clk_sys) disable iff (reset)
    (hs.hall_raw == 3'h0 || hs.hall_raw == 3'h7) |=> $stable(sect_reg))
    else $error("sector changed on invalid hall code");
  trans_pulse_a: assert property (@(posedge clk_sys) disable iff (reset)
    trans_reg |-> (state_reg != $past(state_reg)))
    else $error("transition without state change");
endmodule

// [rtl/hall_sector_if.sv]
// Interface carrying the Hall state and derived sector between modules
`timescale 1ns/1ps
interface hall_sector_if;
  logic [2:0] hall_raw;
  logic [2:0] hall_state;
  logic [13:0] sector_angle;
  logic sector_valid;
  logic transition;
  modport decoder (input hall_raw, output hall_state, output sector_angle,
    output sector_valid, output transition);
  modport user (output hall_raw, input hall_state, input sector_angle,
    input sector_valid, input transition);
endinterface

// [rtl/hall_sine_commutation_init.sv]
// Sine commutation initialisation block with Hall calibration, AHB-Lite registers
// Function
// - Setup command places axis in sine mode
// - Disable argument turns sine initialisation off
// - Sine flag reads one after setup
// - Report second-phase aux index, zero otherwise
// - Hall offset, 1/32 degree, default zero
// - First Hall transition loads precise angle
// - Hall sector commutation until transition, then sine
// - Hall state readable; 0 and 7 invalid
// - Refuse calibration on two-phase; servo only
// - Forced-phase and minimal-motion alternatives offered
// - Select -1 routes Hall pins, 0 clears
// - Manual angle overrides; then tracks current angle
// - Angle spans 0 to 360 at 1/32
//
// Register access over AHB-Lite and the address map are this design's own decisions.
`timescale 1ns/1ps
module hall_sine_commutation_init #(
  parameter int AUX_W = 4
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [2:0] hall_pins,
  input wire logic [13:0] motion_angle_delta,
  input wire logic motion_step,
  input wire logic phase_found,
  output logic [13:0] commutation_angle,
  output logic sine_drive_en,
  output logic forced_phase_run,
  output logic min_motion_run
);
  typedef enum logic [4:0] {
    ST_OFF = 5'b00001,
    ST_HALL = 5'b00010,
    ST_FORCED = 5'b00100,
    ST_FIND = 5'b01000,
    ST_SINE = 5'b10000
  } mode_t;

  hall_sector_if hs ();
  hall_sector_decode u_dec (
    .clk_sys(clk_sys),
    .reset(reset),
    .hs(hs)
  );

  mode_t mode_reg;
  mode_t mode_next;
  logic [AUX_W-1:0] aux_reg;
  logic [AUX_W-1:0] aux_next;
  logic sine_axis_reg;
  logic sine_axis_next;
  logic [2:0] motor_type_select_reg;
  logic [2:0] motor_type_select_next;
  logic hall_input_select_reg;
  logic hall_input_select_next;
  logic two_phase_variant_reg;
  logic two_phase_variant_next;
  logic [15:0] hall_phase_offset_reg;
  logic [15:0] hall_phase_offset_next;
  logic [13:0] angle_reg;
  logic [13:0] angle_next;
  logic [15:0] magnetic_cycle_counts_reg;
  logic [15:0] magnetic_cycle_counts_next;
  logic cal_refused_reg;
  logic cal_refused_next;
  logic wr_pend_reg;
  logic wr_pend_next;
  logic [7:0] addr_reg;
  logic [7:0] addr_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic servo_ok;
  logic take;
  logic wr_now;
  logic [14:0] hall_angle_sum;
  logic [14:0] step_sum;
  logic [13:0] hall_angle;
  logic [13:0] stepped_angle;
  logic [2:0] cmd;

  assign servo_ok = (motor_type_select_reg == sine_commut_pkg::MT_SERVO_POS) ||
    (motor_type_select_reg == sine_commut_pkg::MT_SERVO_NEG);
  assign hs.hall_raw = hall_input_select_reg ? hall_pins : 3'h0;
  assign take = hsel && hready && htrans[1];
  assign wr_now = wr_pend_reg;
  assign cmd = hwdata[2:0];

  // Offset is signed; add full turn and wrap once each way
  always_comb begin
    hall_angle_sum = {1'b0, hs.sector_angle} + 15'(hall_phase_offset_reg);
    if (hall_phase_offset_reg[15]) begin
      hall_angle_sum = {1'b0, hs.sector_angle} + 15'(hall_phase_offset_reg[13:0])
        + 15'(sine_commut_pkg::ANGLE_FULL) - 15'h4000;
    end
    if (hall_angle_sum >= 15'(sine_commut_pkg::ANGLE_FULL)) begin
      hall_angle = 14'(hall_angle_sum - 15'(sine_commut_pkg::ANGLE_FULL));
    end else begin
      hall_angle = hall_angle_sum[13:0];
    end
    step_sum = {1'b0, angle_reg} + {1'b0, motion_angle_delta};
    // A delta may exceed a full turn, so the sum can need two wraps
    if (step_sum >= 15'(2 * sine_commut_pkg::ANGLE_FULL)) begin
      stepped_angle = 14'(step_sum - 15'(2 * sine_commut_pkg::ANGLE_FULL));
    end else if (step_sum >= 15'(sine_commut_pkg::ANGLE_FULL)) begin
      stepped_angle = 14'(step_sum - 15'(sine_commut_pkg::ANGLE_FULL));
    end else begin
      stepped_angle = step_sum[13:0];
    end
  end

  always_comb begin
    mode_next = mode_reg;
    aux_next = aux_reg;
    sine_axis_next = sine_axis_reg;
    motor_type_select_next = motor_type_select_reg;
    hall_input_select_next = hall_input_select_reg;
    two_phase_variant_next = two_phase_variant_reg;
    hall_phase_offset_next = hall_phase_offset_reg;
    angle_next = angle_reg;
    magnetic_cycle_counts_next = magnetic_cycle_counts_reg;
    cal_refused_next = cal_refused_reg;
    wr_pend_next = take && hwrite;
    addr_next = take ? haddr[7:0] : addr_reg;
    rdata_next = rdata_reg;

    case (mode_reg)
      ST_HALL: begin
        // Before any valid code the sector means nothing, so hold the angle
        if (hs.sector_valid) angle_next = hall_angle;
        if (hs.transition) begin
          angle_next = hall_angle;
          mode_next = ST_SINE;
        end
      end
      ST_FORCED, ST_FIND: begin
        if (phase_found) begin
          mode_next = ST_SINE;
        end
      end
      ST_SINE: begin
        if (motion_step) begin
          angle_next = stepped_angle;
        end
      end
      ST_OFF: begin
      end
      default: mode_next = ST_OFF;
    endcase

    if (wr_now) begin
      case (addr_reg)
        sine_commut_pkg::OFF_CTRL: begin
          motor_type_select_next = hwdata[sine_commut_pkg::CTRL_MTYPE_LSB +: 3];
          hall_input_select_next = hwdata[sine_commut_pkg::CTRL_HSEL_BIT];
          two_phase_variant_next = hwdata[sine_commut_pkg::CTRL_TWOPH_BIT];
          aux_next = hwdata[sine_commut_pkg::CTRL_AUX_LSB +: AUX_W];
        end
        sine_commut_pkg::OFF_OFFSET: begin
          // Out-of-range magnitudes are clamped to the limit
          hall_phase_offset_next = hwdata[15:0];
          if (!hwdata[15] && hwdata[14:0] > 15'(sine_commut_pkg::OFFSET_MAX)) begin
            hall_phase_offset_next = {2'b00, sine_commut_pkg::OFFSET_MAX};
          end
          if (hwdata[15] &&
            hwdata[13:0] < 14'(15'h4000 - 15'(sine_commut_pkg::OFFSET_MAX))) begin
            hall_phase_offset_next = {2'b10, 14'(15'h4000 - 15'(sine_commut_pkg::OFFSET_MAX))};
          end
        end
        sine_commut_pkg::OFF_ANGLE: begin
          if (hwdata[13:0] < sine_commut_pkg::ANGLE_FULL) begin
            angle_next = hwdata[13:0];
          end
        end
        sine_commut_pkg::OFF_MCYCLE: magnetic_cycle_counts_next = hwdata[15:0];
        sine_commut_pkg::OFF_CMD: begin
          case (cmd)
            sine_commut_pkg::CMD_SINE_AXIS: begin
              sine_axis_next = 1'b1;
            end
            sine_commut_pkg::CMD_SINE_OFF: begin
              sine_axis_next = 1'b0;
              mode_next = ST_OFF;
            end
            sine_commut_pkg::CMD_HALL_CAL: begin
              if (two_phase_variant_reg || !servo_ok || !sine_axis_reg) begin
                cal_refused_next = 1'b1;
              end else begin
                cal_refused_next = 1'b0;
                mode_next = ST_HALL;
              end
            end
            sine_commut_pkg::CMD_FORCED: begin
              if (servo_ok && sine_axis_reg) mode_next = ST_FORCED;
            end
            sine_commut_pkg::CMD_MINFIND: begin
              if (servo_ok && sine_axis_reg) mode_next = ST_FIND;
            end
            default: begin
            end
          endcase
        end
        default: begin
        end
      endcase
    end

    if (take && !hwrite) begin
      case (haddr[7:0])
        sine_commut_pkg::OFF_CTRL: rdata_next = {16'h0000, 4'h0, 4'(aux_next),
          2'b00, two_phase_variant_reg, hall_input_select_reg, 1'b0,
          motor_type_select_reg};
        sine_commut_pkg::OFF_OFFSET: rdata_next = {16'h0000, hall_phase_offset_reg};
        sine_commut_pkg::OFF_ANGLE: rdata_next = {18'h0_0000, angle_reg};
        sine_commut_pkg::OFF_MCYCLE: rdata_next = {16'h0000, magnetic_cycle_counts_reg};
        sine_commut_pkg::OFF_STATUS: begin
          rdata_next = {16'h0000, 5'h00, mode_reg, cal_refused_reg, sine_axis_reg,
            1'b0, hs.hall_state};
          // Aux index reads zero unless a sine servo axis is set
          rdata_next[31:28] = (sine_axis_reg && servo_ok) ? 4'(aux_reg) : 4'h0;
          rdata_next[4] = sine_axis_reg;
        end
        default: rdata_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      mode_reg <= ST_OFF;
      aux_reg <= AUX_W'(sine_commut_pkg::AUX_RESET);
      sine_axis_reg <= 1'b0;
      motor_type_select_reg <= sine_commut_pkg::MT_SERVO_POS;
      hall_input_select_reg <= 1'b0;
      two_phase_variant_reg <= 1'b0;
      hall_phase_offset_reg <= sine_commut_pkg::OFFSET_RESET;
      angle_reg <= sine_commut_pkg::ANGLE_RESET;
      magnetic_cycle_counts_reg <= sine_commut_pkg::MCYCLE_RESET;
      cal_refused_reg <= 1'b0;
      wr_pend_reg <= 1'b0;
      addr_reg <= 8'h00;
      rdata_reg <= 32'h0000_0000;
    end else begin
      mode_reg <= mode_next;
      aux_reg <= aux_next;
      sine_axis_reg <= sine_axis_next;
      motor_type_select_reg <= motor_type_select_next;
      hall_input_select_reg <= hall_input_select_next;
      two_phase_variant_reg <= two_phase_variant_next;
      hall_phase_offset_reg <= hall_phase_offset_next;
      angle_reg <= angle_next;
      magnetic_cycle_counts_reg <= magnetic_cycle_counts_next;
      cal_refused_reg <= cal_refused_next;
      wr_pend_reg <= wr_pend_next;
      addr_reg <= addr_next;
      rdata_reg <= rdata_next;
    end
  end

  assign hrdata = rdata_reg;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign commutation_angle = angle_reg;
  assign sine_drive_en = (mode_reg == ST_SINE);
  assign forced_phase_run = (mode_reg == ST_FORCED);
  assign min_motion_run = (mode_reg == ST_FIND);

  angle_range_a: assert property (@(posedge clk_sys) disable iff (reset)
    angle_reg < sine_commut_pkg::ANGLE_FULL)
    else $error("angle beyond full turn");
  sine_setup_a: assert property (@(posedge clk_sys) disable iff (reset)
    wr_now && addr_reg == sine_commut_pkg::OFF_CMD && cmd == sine_commut_pkg::CMD_SINE_AXIS
    |=> sine_axis_reg)
    else $error("sine setup not taken");
  sine_off_a: assert property (@(posedge clk_sys) disable iff (reset)
    wr_now && addr_reg == sine_commut_pkg::OFF_CMD && cmd == sine_commut_pkg::CMD_SINE_OFF
    |=> !sine_axis_reg && mode_reg == ST_OFF)
    else $error("sine disable not taken");
  cal_refuse_a: assert property (@(posedge clk_sys) disable iff (reset)
    wr_now && addr_reg == sine_commut_pkg::OFF_CMD && cmd == sine_commut_pkg::CMD_HALL_CAL
    && two_phase_variant_reg |=> cal_refused_reg && mode_reg != ST_HALL)
    else $error("calibration accepted on two-phase variant");
  first_trans_a: assert property (@(posedge clk_sys) disable iff (reset)
    mode_reg == ST_HALL && hs.transition && !wr_now
    |=> mode_reg == ST_SINE && angle_reg == $past(hall_angle))
    else $error("first hall transition not applied");
  offset_clamp_a: assert property (@(posedge clk_sys) disable iff (reset)
    hall_phase_offset_reg[15] ? hall_phase_offset_reg[13:0] >=
    14'(15'h4000 - 15'(sine_commut_pkg::OFFSET_MAX)) :
    hall_phase_offset_reg[14:0] <= 15'(sine_commut_pkg::OFFSET_MAX))
    else $error("offset beyond limit");
  hall_route_a: assert property (@(posedge clk_sys) disable iff (reset)
    !hall_input_select_reg |-> ##2 hs.hall_state == 3'h0 || hall_input_select_reg)
    else $error("hall inputs not cleared");
  manual_angle_a: assert property (@(posedge clk_sys) disable iff (reset)
    wr_now && addr_reg == sine_commut_pkg::OFF_ANGLE
    && hwdata[13:0] < sine_commut_pkg::ANGLE_FULL
    && mode_reg != ST_HALL |=> angle_reg == $past(hwdata[13:0]))
    else $error("manual angle not applied");
endmodule

// [rtl/sine_commut_pkg.sv]
// Package with register map, field layouts and constants of the commutation init block
package sine_commut_pkg;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_OFFSET = 8'h04;
  localparam logic [7:0] OFF_ANGLE = 8'h08;
  localparam logic [7:0] OFF_CMD = 8'h0C;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  localparam logic [7:0] OFF_MCYCLE = 8'h14;
  // CTRL fields
  localparam int CTRL_MTYPE_LSB = 0;
  localparam int CTRL_HSEL_BIT = 4;
  localparam int CTRL_TWOPH_BIT = 5;
  localparam int CTRL_AUX_LSB = 8;
  // CMD codes written to OFF_CMD
  localparam logic [2:0] CMD_SINE_AXIS = 3'h1;
  localparam logic [2:0] CMD_SINE_OFF = 3'h2;
  localparam logic [2:0] CMD_HALL_CAL = 3'h3;
  localparam logic [2:0] CMD_FORCED = 3'h4;
  localparam logic [2:0] CMD_MINFIND = 3'h5;
  // Motor type codes: servo 1 and -1 in 3-bit two's complement
  localparam logic [2:0] MT_SERVO_POS = 3'h1;
  localparam logic [2:0] MT_SERVO_NEG = 3'h7;
  localparam int ANGLE_W = 14;
  // 360 degrees at 1/32 degree
  localparam logic [13:0] ANGLE_FULL = 14'h2D00;
  // 359.98 deg rounded to 1/32 steps
  localparam logic [13:0] OFFSET_MAX = 14'h2CFF;
  localparam logic [13:0] SECTOR_STEP = 14'h0780;
  localparam logic [13:0] ANGLE_RESET = 14'h0000;
  localparam logic [15:0] OFFSET_RESET = 16'h0000;
  localparam logic [3:0] AUX_RESET = 4'h1;
  localparam logic [15:0] MCYCLE_RESET = 16'h0000;
endpackage
